/* File: pkg/pxa_pkg.sv */
// Package for the parity accelerator: descriptor layout, modes, states.
// Assumes a single 250 MHz clock domain and 32-bit local memory words.
package pxa_pkg;
    localparam int DATA_W       = 32;
    localparam int ADDR_W       = 32;
    localparam int FIFO_DEPTH   = 16;
    localparam int MAX_SRC      = 8;
    localparam int SRC_CNT_W    = 4;
    localparam int LEN_W        = 16;
    localparam int CTRL_W       = 8;
    // Global control: dual-parity enable bit position
    localparam int CTRL_DUAL_BIT = 3;
    localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
    // Multiplier byte that leaves a source unchanged
    localparam logic [7:0] GF_ONE  = 8'h01;
    // Reduction polynomial low byte for x^8+x^4+x^3+x^2+1
    localparam logic [7:0] GF_POLY = 8'h1D;
    // Destination selector: 0 local memory, 1 host through translation
    localparam logic DST_LOCAL = 1'b0;
    localparam logic DST_HOST  = 1'b1;
    typedef enum logic [2:0] {
        PXA_IDLE, PXA_RD, PXA_WAIT, PXA_ACC, PXA_WR, PXA_DONE
    } pxa_state_t;
endpackage

/* File: src/pxa_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; full and empty are exact.
`timescale 1ns/10ps
module pxa_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             arst_n,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_ff, rp_ff, nxt_wp, nxt_rp;
    logic [AW:0]      cnt_ff, nxt_cnt;
    logic             push, pop;

    always_comb begin
        in_ready  = (cnt_ff != (AW+1)'(DEPTH));
        out_valid = (cnt_ff != '0);
        out_data  = mem[rp_ff];
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        nxt_wp    = push ? AW'(wp_ff + 1'b1) : wp_ff;
        nxt_rp    = pop ? AW'(rp_ff + 1'b1) : rp_ff;
        nxt_cnt   = cnt_ff;
        if (push && !pop) begin
            nxt_cnt = (AW+1)'(cnt_ff + 1'b1);
        end else if (pop && !push) begin
            nxt_cnt = (AW+1)'(cnt_ff - 1'b1);
        end
    end

    // Storage has no reset; only pointers and count need a defined start
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_ff] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wp_ff  <= '0;
            rp_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            wp_ff  <= nxt_wp;
            rp_ff  <= nxt_rp;
            cnt_ff <= nxt_cnt;
        end
    end
endmodule // pxa_fifo

/* File: src/pxa_top.sv */
// Parity accelerator: fetches source blocks, computes XOR or P+Q parity,
// writes results to local memory or host memory via translation unit.
// Assumes memory answers reads with one rd_valid pulse per request.
`timescale 1ns/10ps
module pxa_top
    import pxa_pkg::*;
(
    // Clock and reset
    input  wire logic                 CLK_SYS,
    input  wire logic                 ARST_N,
    // Global control
    input  wire logic [CTRL_W-1:0]    ACCEL_CONTROL_REG,
    // Descriptor
    input  wire logic                 DESC_VALID,
    output logic                      DESC_READY,
    input  wire logic [SRC_CNT_W-1:0] DESC_NSRC,
    input  wire logic [LEN_W-1:0]     DESC_WORDS,
    input  wire logic [ADDR_W-1:0]    DESC_SRC_STRIDE,
    input  wire logic [ADDR_W-1:0]    DESC_SRC_BASE,
    input  wire logic [ADDR_W-1:0]    DESC_DST_P,
    input  wire logic [ADDR_W-1:0]    DESC_DST_Q,
    input  wire logic                 DESC_DST_SEL,
    input  wire logic [8*MAX_SRC-1:0] DESC_GF_MULT,
    // Local memory read port
    output logic                      RD_REQ,
    output logic [ADDR_W-1:0]         RD_ADDR,
    input  wire logic                 RD_ACK,
    input  wire logic                 RD_VALID,
    input  wire logic [DATA_W-1:0]    RD_DATA,
    // Result stream
    output logic                      WR_VALID,
    input  wire logic                 WR_READY,
    output logic [ADDR_W-1:0]         WR_ADDR,
    output logic [DATA_W-1:0]         WR_DATA,
    output logic                      WR_TO_HOST,
    // Status
    output logic                      BUSY,
    output logic                      DONE
);
    localparam int FW = ADDR_W + DATA_W + 1;
    function automatic logic [7:0] gf_mul(input logic [7:0] a,
                                          input logic [7:0] b);
        logic [7:0] p, x;
        p = 8'h00;
        x = a;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) begin
                p = p ^ x;
            end
            x = x[7] ? ((x << 1) ^ GF_POLY) : (x << 1);
        end
        return p;
    endfunction
    pxa_state_t st_ff, nxt_st;
    logic                 dual_ff, nxt_dual;
    logic [SRC_CNT_W-1:0] nsrc_ff, nxt_nsrc, si_ff, nxt_si;
    logic [LEN_W-1:0]     words_ff, nxt_words, wi_ff, nxt_wi;
    logic [ADDR_W-1:0]    stride_ff, nxt_stride, base_ff, nxt_base;
    logic [ADDR_W-1:0]    dp_ff, nxt_dp, dq_ff, nxt_dq;
    logic                 host_ff, nxt_host;
    logic [8*MAX_SRC-1:0] mult_ff, nxt_mult;
    logic [DATA_W-1:0]    p_ff, nxt_p, q_ff, nxt_q, dat_ff, nxt_dat;
    logic                 qph_ff, nxt_qph;
    logic                 rdq_ff, nxt_rdq;
    logic [ADDR_W-1:0]    rda_ff, nxt_rda;
    logic                 done_ff, nxt_done;
    logic                 dsc_rdy_ff, nxt_dsc_rdy, busy_ff, nxt_busy;
    logic                 f_valid, f_ready;
    logic [FW-1:0]        f_data;
    logic [DATA_W-1:0]    q_term;
    logic [7:0]           mbyte;
    // Byte-lane multiply of the fetched word by this source's multiplier
    assign mbyte = mult_ff[8*si_ff +: 8];
    for (genvar b = 0; b < DATA_W/8; b++) begin : g_lane
        assign q_term[8*b +: 8] = gf_mul(dat_ff[8*b +: 8], mbyte);
    end
    always_comb begin
        nxt_st      = st_ff;
        nxt_dual    = dual_ff;
        nxt_nsrc    = nsrc_ff;
        nxt_words   = words_ff;
        nxt_stride  = stride_ff;
        nxt_base    = base_ff;
        nxt_dp      = dp_ff;
        nxt_dq      = dq_ff;
        nxt_host    = host_ff;
        nxt_mult    = mult_ff;
        nxt_p       = p_ff;
        nxt_q       = q_ff;
        nxt_dat     = dat_ff;
        nxt_si      = si_ff;
        nxt_wi      = wi_ff;
        nxt_qph     = qph_ff;
        nxt_rdq     = rdq_ff;
        nxt_rda     = rda_ff;
        nxt_done    = 1'b0;
        nxt_dsc_rdy = 1'b0;
        f_valid     = 1'b0;
        f_data      = '0;
        unique case (st_ff)
            PXA_IDLE: begin
                nxt_dsc_rdy = 1'b1;
                if (DESC_VALID && dsc_rdy_ff) begin
                    nxt_dsc_rdy = 1'b0;
                    // Mode is latched per descriptor from the global bit
                    nxt_dual   = ACCEL_CONTROL_REG[CTRL_DUAL_BIT];
                    nxt_nsrc   = DESC_NSRC;
                    nxt_words  = DESC_WORDS;
                    nxt_stride = DESC_SRC_STRIDE;
                    nxt_base   = DESC_SRC_BASE;
                    nxt_dp     = DESC_DST_P;
                    nxt_dq     = DESC_DST_Q;
                    nxt_host   = DESC_DST_SEL;
                    nxt_mult   = DESC_GF_MULT;
                    nxt_wi     = '0;
                    nxt_si     = '0;
                    nxt_p      = '0;
                    nxt_q      = '0;
                    // Empty descriptors complete without touching memory
                    if (DESC_NSRC == '0 || DESC_WORDS == '0) begin
                        nxt_st = PXA_DONE;
                    end else begin
                        nxt_st = PXA_RD;
                    end
                end
            end
            PXA_RD: begin
                // Source address is always a local memory address
                nxt_rdq = 1'b1;
                nxt_rda = base_ff + ADDR_W'(si_ff) * stride_ff
                          + (ADDR_W'(wi_ff) << 2);
                if (rdq_ff && RD_ACK) begin
                    nxt_rdq = 1'b0;
                    nxt_st  = PXA_WAIT;
                end
            end
            PXA_WAIT: begin
                if (RD_VALID) begin
                    nxt_dat = RD_DATA;
                    nxt_st  = PXA_ACC;
                end
            end
            PXA_ACC: begin
                nxt_p = p_ff ^ dat_ff;
                if (dual_ff) begin
                    nxt_q = q_ff ^ q_term;
                end
                if (si_ff == SRC_CNT_W'(nsrc_ff - 1'b1)) begin
                    nxt_si  = '0;
                    nxt_qph = 1'b0;
                    nxt_st  = PXA_WR;
                end else begin
                    nxt_si = SRC_CNT_W'(si_ff + 1'b1);
                    nxt_st = PXA_RD;
                end
            end
            PXA_WR: begin
                // FIFO back-pressure stalls the engine here
                f_valid = 1'b1;
                f_data  = qph_ff ?
                    {dq_ff + (ADDR_W'(wi_ff) << 2), q_ff, host_ff} :
                    {dp_ff + (ADDR_W'(wi_ff) << 2), p_ff, host_ff};
                if (f_ready) begin
                    if (dual_ff && !qph_ff) begin
                        nxt_qph = 1'b1;
                    end else begin
                        nxt_p = '0;
                        nxt_q = '0;
                        if (wi_ff == LEN_W'(words_ff - 1'b1)) begin
                            nxt_st = PXA_DONE;
                        end else begin
                            nxt_wi = LEN_W'(wi_ff + 1'b1);
                            nxt_st = PXA_RD;
                        end
                    end
                end
            end
            PXA_DONE: begin
                nxt_done = 1'b1;
                nxt_st   = PXA_IDLE;
            end
            default: nxt_st = PXA_IDLE;
        endcase
        nxt_busy = !nxt_dsc_rdy;
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            st_ff      <= PXA_IDLE;
            dual_ff    <= 1'b0;
            nsrc_ff    <= '0;
            words_ff   <= '0;
            stride_ff  <= '0;
            base_ff    <= '0;
            dp_ff      <= '0;
            dq_ff      <= '0;
            host_ff    <= DST_LOCAL;
            mult_ff    <= '0;
            p_ff       <= '0;
            q_ff       <= '0;
            dat_ff     <= '0;
            si_ff      <= '0;
            wi_ff      <= '0;
            qph_ff     <= 1'b0;
            rdq_ff     <= 1'b0;
            rda_ff     <= '0;
            done_ff    <= 1'b0;
            dsc_rdy_ff <= 1'b0;
            busy_ff    <= 1'b1;
        end else begin
            st_ff      <= nxt_st;
            dual_ff    <= nxt_dual;
            nsrc_ff    <= nxt_nsrc;
            words_ff   <= nxt_words;
            stride_ff  <= nxt_stride;
            base_ff    <= nxt_base;
            dp_ff      <= nxt_dp;
            dq_ff      <= nxt_dq;
            host_ff    <= nxt_host;
            mult_ff    <= nxt_mult;
            p_ff       <= nxt_p;
            q_ff       <= nxt_q;
            dat_ff     <= nxt_dat;
            si_ff      <= nxt_si;
            wi_ff      <= nxt_wi;
            qph_ff     <= nxt_qph;
            rdq_ff     <= nxt_rdq;
            rda_ff     <= nxt_rda;
            done_ff    <= nxt_done;
            dsc_rdy_ff <= nxt_dsc_rdy;
            busy_ff    <= nxt_busy;
        end
    end

    // Output stage registers the FIFO head so outputs come from flops
    logic              o_valid_ff, nxt_o_valid, o_host_ff, nxt_o_host;
    logic [ADDR_W-1:0] o_addr_ff, nxt_o_addr;
    logic [DATA_W-1:0] o_data_ff, nxt_o_data;
    logic              g_valid, g_ready;
    logic [FW-1:0]     g_data;
    pxa_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (CLK_SYS),
        .arst_n    (ARST_N),
        .in_valid  (f_valid),
        .in_ready  (f_ready),
        .in_data   (f_data),
        .out_valid (g_valid),
        .out_ready (g_ready),
        .out_data  (g_data)
    );
    always_comb begin
        g_ready     = !o_valid_ff || WR_READY;
        nxt_o_valid = o_valid_ff && !WR_READY;
        nxt_o_addr  = o_addr_ff;
        nxt_o_data  = o_data_ff;
        nxt_o_host  = o_host_ff;
        if (g_valid && g_ready) begin
            nxt_o_valid = 1'b1;
            nxt_o_addr  = g_data[FW-1 -: ADDR_W];
            nxt_o_data  = g_data[DATA_W:1];
            nxt_o_host  = g_data[0];
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            o_valid_ff <= 1'b0;
            o_addr_ff  <= '0;
            o_data_ff  <= '0;
            o_host_ff  <= DST_LOCAL;
        end else begin
            o_valid_ff <= nxt_o_valid;
            o_addr_ff  <= nxt_o_addr;
            o_data_ff  <= nxt_o_data;
            o_host_ff  <= nxt_o_host;
        end
    end

    assign DESC_READY = dsc_rdy_ff;
    assign RD_REQ     = rdq_ff;
    assign RD_ADDR    = rda_ff;
    assign WR_VALID   = o_valid_ff;
    assign WR_ADDR    = o_addr_ff;
    assign WR_DATA    = o_data_ff;
    assign WR_TO_HOST = o_host_ff;
    assign DONE       = done_ff;
    assign BUSY       = busy_ff;
endmodule // pxa_top

/* File: bench/pxa_props.sv */
// Checker on the parity accelerator top ports.
// Bound into pxa_top; one clock, async active-low reset.
`timescale 1ns/10ps
module pxa_props
    import pxa_pkg::*;
(
    // Clock and reset
    input wire logic              CLK_SYS,
    input wire logic              ARST_N,
    // Descriptor and status
    input wire logic              DESC_VALID,
    input wire logic              DESC_READY,
    input wire logic              BUSY,
    input wire logic              DONE,
    // Read port
    input wire logic              RD_REQ,
    input wire logic [ADDR_W-1:0] RD_ADDR,
    input wire logic              RD_ACK,
    input wire logic              RD_VALID,
    // Result stream
    input wire logic              WR_VALID,
    input wire logic              WR_READY,
    input wire logic [ADDR_W-1:0] WR_ADDR,
    input wire logic [DATA_W-1:0] WR_DATA,
    input wire logic              WR_TO_HOST
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!ARST_N);
    chk_rd_hold:
        assert property (RD_REQ && !RD_ACK |=> RD_REQ && $stable(RD_ADDR))
        else $error("read request dropped or moved");
    chk_rd_drop:
        assert property (RD_REQ && RD_ACK |=> !RD_REQ)
        else $error("read request held after accept");
    chk_rd_single:
        assert property (RD_VALID |-> !RD_REQ ##1 !RD_REQ)
        else $error("read issued too soon after data");
    chk_wr_hold:
        assert property (WR_VALID && !WR_READY |=> WR_VALID
            && $stable(WR_ADDR) && $stable(WR_DATA) && $stable(WR_TO_HOST))
        else $error("stalled result word changed");
    chk_busy_ready:
        assert property (BUSY != DESC_READY)
        else $error("busy and ready disagree");
    chk_take_busy:
        assert property (DESC_VALID && DESC_READY |=> !DESC_READY)
        else $error("ready stayed high after take");
    chk_done_pulse:
        assert property (DONE |=> !DONE)
        else $error("done longer than one cycle");
    chk_done_ready:
        assert property (DONE |-> ##[1:3] DESC_READY)
        else $error("ready not back after done");
    cover property (DONE);
    cover property (WR_VALID && !WR_READY);
    cover property (RD_REQ && RD_ACK);
endmodule // pxa_props

bind pxa_top pxa_props pxa_props_inst (
    .CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .DESC_VALID(DESC_VALID),
    .DESC_READY(DESC_READY), .BUSY(BUSY), .DONE(DONE),
    .RD_REQ(RD_REQ), .RD_ADDR(RD_ADDR), .RD_ACK(RD_ACK),
    .RD_VALID(RD_VALID), .WR_VALID(WR_VALID), .WR_READY(WR_READY),
    .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA), .WR_TO_HOST(WR_TO_HOST)
);

/* File: bench/pxa_mem_model.sv */
// Local memory read port and result sink seen by the accelerator.
// Drives at the falling edge; read delay is short or long by a phase bit that flips every cycle.
`timescale 1ns/10ps
module pxa_mem_model
    import pxa_pkg::*;
(
    // Clock
    input  wire logic              clk,
    // Local memory read port
    input  wire logic              rd_req,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic                   rd_ack,
    output logic                   rd_valid,
    output logic [DATA_W-1:0]      rd_data,
    // Result sink
    input  wire logic              stall,
    output logic                   wr_ready
);
    logic [ADDR_W-1:0] a_q = '0;
    logic [2:0]        cnt = 3'h0;
    logic              slow = 1'b0;
    initial begin
        rd_ack = 1'b0;
        rd_valid = 1'b0;
        rd_data = '0;
        wr_ready = 1'b0;
    end
    function automatic logic [DATA_W-1:0] mem_word(input logic [31:0] a);
        return {a[15:0], a[31:16]} ^ 32'h5A3C_96E1;
    endfunction
    // Only local words are served; idle data flips so nothing stale passes
    always @(negedge clk) begin
        rd_ack <= 1'b0;
        rd_valid <= 1'b0;
        rd_data <= ~rd_data;
        slow <= ~slow;
        wr_ready <= !stall && !slow;
        if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
            if (cnt == 3'h1) begin
                rd_valid <= 1'b1;
                rd_data <= mem_word(a_q);
            end
        end else if (rd_req && !rd_ack && !rd_valid) begin
            rd_ack <= 1'b1;
            a_q <= rd_addr;
            cnt <= slow ? 3'h4 : 3'h1;
        end
    end
endmodule // pxa_mem_model

/* File: bench/testbench.sv */
// Self-checking bench for the parity accelerator.
// Assumes pxa_mem_model serves reads and paces the result sink.
`timescale 1ns/10ps
module testbench
    import pxa_pkg::*;
;
    logic clk_sys = 1'b0, arst_n = 1'b0, desc_valid = 1'b0, stall = 1'b0;
    logic [CTRL_W-1:0] ctrl = CTRL_RST;
    logic [SRC_CNT_W-1:0] nsrc = '0;
    logic [LEN_W-1:0] words = '0;
    logic host = 1'b0;
    logic [8*MAX_SRC-1:0] mult = '0;
    logic desc_ready, busy, done, rd_req, rd_ack, rd_valid;
    logic wr_valid, wr_ready, wr_host;
    logic [ADDR_W-1:0] rd_addr, wr_addr;
    logic [DATA_W-1:0] rd_data, wr_data;
    logic [64:0] wq[$];
    int n_fail = 0;
    int n_checks = 0;
    always #2 clk_sys = ~clk_sys;
    pxa_top pxa_top_inst (
        .CLK_SYS(clk_sys), .ARST_N(arst_n), .ACCEL_CONTROL_REG(ctrl),
        .DESC_VALID(desc_valid), .DESC_READY(desc_ready), .DESC_NSRC(nsrc),
        .DESC_WORDS(words), .DESC_SRC_STRIDE(32'h0000_0100),
        .DESC_SRC_BASE(32'h0000_1000), .DESC_DST_P(32'h0000_8000),
        .DESC_DST_Q(32'h0000_C000), .DESC_DST_SEL(host), .DESC_GF_MULT(mult),
        .RD_REQ(rd_req), .RD_ADDR(rd_addr), .RD_ACK(rd_ack),
        .RD_VALID(rd_valid), .RD_DATA(rd_data), .WR_VALID(wr_valid),
        .WR_READY(wr_ready), .WR_ADDR(wr_addr), .WR_DATA(wr_data),
        .WR_TO_HOST(wr_host), .BUSY(busy), .DONE(done)
    );
    pxa_mem_model pxa_mem_model_inst (
        .clk(clk_sys), .rd_req(rd_req), .rd_addr(rd_addr), .rd_ack(rd_ack),
        .rd_valid(rd_valid), .rd_data(rd_data), .stall(stall),
        .wr_ready(wr_ready)
    );
    always @(posedge clk_sys) begin
        if (wr_valid && wr_ready) wq.push_back({wr_host, wr_addr, wr_data});
    end
    task automatic check(input logic [64:0] seen, input logic [64:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    function automatic logic [31:0] mem_word(input logic [31:0] a);
        return {a[15:0], a[31:16]} ^ 32'h5A3C_96E1;
    endfunction
    // Byte-lane field product, shift-and-add
    function automatic logic [31:0] gfw(input logic [31:0] d,
                                        input logic [7:0] m);
        logic [31:0] r;
        logic [7:0] a;
        r = '0;
        for (int b = 0; b < 4; b++) begin
            a = d[8*b +: 8];
            for (int k = 0; k < 8; k++) begin
                if (m[k]) r[8*b +: 8] ^= a;
                a = {a[6:0], 1'b0} ^ (a[7] ? GF_POLY : 8'h00);
            end
        end
        return r;
    endfunction
    // Offers one job, flips the mode bit after take, checks every write
    task automatic run_job(input logic [7:0] c, input int n, input int w,
                           input logic h, input logic [63:0] m);
        logic [31:0] p, q, d;
        int k, cnt;
        cnt = c[CTRL_DUAL_BIT] ? 2 * w : w;
        wq.delete();
        ctrl = c;
        nsrc = n[SRC_CNT_W-1:0];
        words = w[LEN_W-1:0];
        host = h;
        mult = m;
        for (k = 0; k < 100 && desc_ready !== 1'b1; k++) @(negedge clk_sys);
        desc_valid = 1'b1;
        @(negedge clk_sys);
        desc_valid = 1'b0;
        ctrl = c ^ 8'h08;
        for (k = 0; k < 3000 && done !== 1'b1; k++) @(negedge clk_sys);
        check(done, 1'b1);
        for (k = 0; k < 300 && wq.size() < cnt; k++) @(negedge clk_sys);
        check(wq.size(), cnt);
        for (int i = 0; i < w; i++) begin
            p = '0;
            q = '0;
            for (int s = 0; s < n; s++) begin
                d = mem_word(32'h0000_1000 + s * 32'h100 + 4 * i);
                p ^= d;
                q ^= gfw(d, m[8*s +: 8]);
            end
            check(wq.pop_front(), {h, 32'h0000_8000 + 4 * i, p});
            if (c[CTRL_DUAL_BIT]) begin
                check(wq.pop_front(), {h, 32'h0000_C000 + 4 * i, q});
            end
        end
    endtask
    // Other control bits set, bit 3 clear: multipliers must be ignored
    task automatic t_legacy();
        run_job(8'hF7, 3, 2, DST_LOCAL, {8{8'h02}});
    endtask
    // Eight sources, all multipliers one, results to host
    task automatic t_dual_one();
        run_job(8'h08, 8, 2, DST_HOST, {8{GF_ONE}});
    endtask
    // Sink stalls long enough to fill the buffer, then drains
    task automatic t_dual_gf();
        stall <= 1'b1;
        fork
            run_job(8'h08, 2, 12, DST_LOCAL, 64'h0302);
            begin
                repeat (150) @(negedge clk_sys);
                check({wr_valid, busy}, 2'b11);
                stall <= 1'b0;
            end
        join
    endtask
    // Empty job ends with no traffic; a reset then cuts a running job short
    task automatic t_empty_reset();
        int k;
        wq.delete();
        ctrl = 8'h08;
        nsrc = '0;
        words = 16'h0002;
        for (k = 0; k < 100 && desc_ready !== 1'b1; k++) @(negedge clk_sys);
        desc_valid = 1'b1;
        @(negedge clk_sys);
        desc_valid = 1'b0;
        @(negedge clk_sys);
        check({done, rd_req}, 2'b10);
        repeat (20) @(negedge clk_sys);
        check(wq.size(), 0);
        nsrc = 4'h2;
        words = 16'h0004;
        desc_valid = 1'b1;
        @(negedge clk_sys);
        desc_valid = 1'b0;
        repeat (10) @(negedge clk_sys);
        arst_n = 1'b0;
        @(negedge clk_sys);
        check({busy, desc_ready, rd_req, wr_valid, done}, 5'b10000);
        // Long enough for any read still in flight at the memory to finish
        repeat (8) @(negedge clk_sys);
        wq.delete();
        arst_n = 1'b1;
        @(negedge clk_sys);
        check({busy, desc_ready, done}, 3'b010);
        run_job(8'h08, 2, 2, DST_HOST, 64'h0905);
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        check({busy, desc_ready, rd_req, wr_valid, done}, 5'b10000);
        @(negedge clk_sys);
        arst_n = 1'b1;
        t_legacy();
        t_dual_one();
        t_dual_gf();
        t_empty_reset();
        t_legacy();
        conclude();
    end
    // A hung handshake ends the run as a failure
    initial begin
        #60000;
        n_fail++;
        conclude();
    end
endmodule // testbench
